// File: src/pcr_pkg.sv
package pcr_pkg;
	// ------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------
	localparam logic [7:0] PCR_CTRL_OFF = 8'h00;
	localparam logic [7:0] PCR_STAT_OFF = 8'h04;
	// ------------------------------------------------
	// control field positions
	// ------------------------------------------------
	localparam int PCR_IRQ_EN_BIT = 26;
	localparam int PCR_FILT_EN_BIT = 25;
	localparam int PCR_FCNT_HI = 24;
	localparam int PCR_FCNT_LO = 17;
	localparam int PCR_EDGE_BIT = 11;
	localparam int PCR_BOR_HI = 10;
	localparam int PCR_BOR_LO = 9;
	localparam int PCR_THR_HI = 8;
	localparam int PCR_THR_LO = 5;
	localparam int PCR_MON_EN_BIT = 4;
	localparam int PCR_DBG_CLR_BIT = 3;
	localparam int PCR_WAKE_CLR_BIT = 2;
	localparam int PCR_MODE_BIT = 1;
	localparam int PCR_WDG_BIT = 0;
	// ------------------------------------------------
	// status field positions
	// ------------------------------------------------
	localparam int PCR_ST_WAKE_BIT = 0;
	localparam int PCR_ST_DBG_BIT = 1;
	localparam int PCR_ST_MON_BIT = 2;
	// ------------------------------------------------
	// reset values and masks
	// ------------------------------------------------
	localparam logic [31:0] PCR_CTRL_RESET = 32'h0000_0601;
	localparam logic [31:0] PCR_CTRL_WMASK = 32'h07fe_0ff3;
	localparam logic [31:0] PCR_BOR_MASK = 32'h0000_0600;
	// ------------------------------------------------
	// timing counts
	// ------------------------------------------------
	localparam int PCR_WAKE_CLR_CYC = 2;
endpackage

// File: src/pcr_power_control.sv
// Functional notes
// - bit 26 gates monitor interrupt
// - bit 25 enables monitor output filter
// - bits 24:17 filter width in low-speed periods
// - bit 11 selects reset pin edge
// - bits 10:9 stop brown-out level, POR-only clear
// - bits 8:5 monitor threshold select
// - bit 4 enables voltage monitor
// - wake clear acts two cycles after write
// - wake clear bit reads zero
// - deep sleep: stop or power-down by bit 1
// - bit 0 gates watchdog reset request
// - debug clear bit clears flag, reads zero
// - wake pin event sets wake flag
// - monitor output valid only when enabled
`timescale 1ns/1ps
`default_nettype none
module pcr_power_control
	import pcr_pkg::*;
(
	// clock and resets
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic core_por_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// monitor and low-speed clock pins
	input wire logic monitor_cmp_i,
	input wire logic low_speed_oscillator_i,
	// same-clock events
	input wire logic cpu_deep_sleep_signal_i,
	input wire logic wake_pin_event_i,
	input wire logic debug_pd_entry_i,
	input wire logic watchdog_reset_req_i,
	// control outputs
	output logic stop_mode_o,
	output logic power_down_mode_o,
	output logic watchdog_sys_reset_o,
	output logic reset_pin_edge_select_o,
	output logic [1:0] stop_brownout_level_o,
	output logic [3:0] monitor_threshold_select_o,
	output logic voltage_monitor_enable_o,
	output logic voltage_monitor_irq_o,
	output logic voltage_monitor_output_o,
	output logic wake_event_flag_o,
	output logic debug_powerdown_flag_o
);
	import pcr_pkg::*;

	// ------------------------------------------------
	// state
	// ------------------------------------------------
	typedef struct packed {
		logic [31:0] ctrl;
		logic ack;
		logic [31:0] rdata;
		logic [1:0] clr_pipe;
		logic wake_f;
		logic dbg_f;
		logic cmp_m;
		logic cmp_s;
		logic lsi_m;
		logic lsi_s;
		logic lsi_p;
		logic [7:0] run;
		logic filt;
		logic irq;
		logic stop;
		logic pd;
		logic wdrst;
	} pcr_state_t;

	pcr_state_t s_q;
	pcr_state_t s_d;

	logic req;
	logic wr_ctrl;
	logic lsi_rise;
	logic [7:0] fcnt;
	logic [31:0] wval;

	function automatic logic [31:0] pcr_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ------------------------------------------------
	// next state
	// ------------------------------------------------
	always_comb begin
		s_d = s_q;
		req = cyc_i && stb_i;
		wr_ctrl = req && we_i && s_q.ack && (adr_i == PCR_CTRL_OFF);
		lsi_rise = s_q.lsi_s && !s_q.lsi_p;
		fcnt = s_q.ctrl[PCR_FCNT_HI:PCR_FCNT_LO];
		wval = pcr_merge(32'h0000_0000, dat_i, sel_i);
		// bus handshake, one cycle to answer
		s_d.ack = req && !s_q.ack;
		s_d.rdata = 32'h0000_0000;
		if (req && !s_q.ack && !we_i) begin
			if (adr_i == PCR_CTRL_OFF) begin
				s_d.rdata = s_q.ctrl;
			end else if (adr_i == PCR_STAT_OFF) begin
				s_d.rdata[PCR_ST_WAKE_BIT] = s_q.wake_f;
				s_d.rdata[PCR_ST_DBG_BIT] = s_q.dbg_f;
				s_d.rdata[PCR_ST_MON_BIT] = s_q.filt;
			end
		end
		// control write, reserved and clear bits not stored
		if (wr_ctrl) begin
			s_d.ctrl = (pcr_merge(s_q.ctrl, dat_i, sel_i) & PCR_CTRL_WMASK)
				| (PCR_CTRL_RESET & ~PCR_CTRL_WMASK);
		end
		// wake flag clear pipeline
		s_d.clr_pipe = {s_q.clr_pipe[0], wr_ctrl && wval[PCR_WAKE_CLR_BIT]};
		if (s_q.clr_pipe[PCR_WAKE_CLR_CYC-1]) begin
			s_d.wake_f = 1'b0;
		end
		if (wake_pin_event_i) begin
			s_d.wake_f = 1'b1;
		end
		if (wr_ctrl && wval[PCR_DBG_CLR_BIT]) begin
			s_d.dbg_f = 1'b0;
		end
		if (debug_pd_entry_i) begin
			s_d.dbg_f = 1'b1;
		end
		// synchronisers
		s_d.cmp_m = monitor_cmp_i;
		s_d.cmp_s = s_q.cmp_m;
		s_d.lsi_m = low_speed_oscillator_i;
		s_d.lsi_s = s_q.lsi_m;
		s_d.lsi_p = s_q.lsi_s;
		// monitor filter
		if (!s_q.ctrl[PCR_MON_EN_BIT]) begin
			s_d.filt = 1'b0;
			s_d.run = 8'h00;
		end else if (!s_q.ctrl[PCR_FILT_EN_BIT] || fcnt == 8'h00) begin
			s_d.filt = s_q.cmp_s;
			s_d.run = 8'h00;
		end else if (s_q.cmp_s == s_q.filt) begin
			s_d.run = 8'h00;
		end else if (lsi_rise) begin
			if (8'(s_q.run + 8'h01) >= fcnt) begin
				s_d.filt = s_q.cmp_s;
				s_d.run = 8'h00;
			end else begin
				s_d.run = 8'(s_q.run + 8'h01);
			end
		end
		s_d.irq = s_q.ctrl[PCR_MON_EN_BIT] && s_q.ctrl[PCR_IRQ_EN_BIT] && s_q.filt;
		// deep sleep mode choice
		s_d.stop = cpu_deep_sleep_signal_i && !s_q.ctrl[PCR_MODE_BIT];
		s_d.pd = cpu_deep_sleep_signal_i && s_q.ctrl[PCR_MODE_BIT];
		s_d.wdrst = watchdog_reset_req_i && s_q.ctrl[PCR_WDG_BIT];
	end

	// ------------------------------------------------
	// registers
	// ------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (core_por_i) begin
			s_q <= '0;
			s_q.ctrl <= PCR_CTRL_RESET;
		end else if (rst_i) begin
			s_q <= '0;
			s_q.ctrl <= (PCR_CTRL_RESET & ~PCR_BOR_MASK) | (s_q.ctrl & PCR_BOR_MASK);
			s_q.wake_f <= s_q.wake_f;
			s_q.dbg_f <= s_q.dbg_f;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------
	// outputs
	// ------------------------------------------------
	assign dat_o = s_q.rdata;
	assign ack_o = s_q.ack;
	assign stop_mode_o = s_q.stop;
	assign power_down_mode_o = s_q.pd;
	assign watchdog_sys_reset_o = s_q.wdrst;
	assign reset_pin_edge_select_o = s_q.ctrl[PCR_EDGE_BIT];
	assign stop_brownout_level_o = s_q.ctrl[PCR_BOR_HI:PCR_BOR_LO];
	assign monitor_threshold_select_o = s_q.ctrl[PCR_THR_HI:PCR_THR_LO];
	assign voltage_monitor_enable_o = s_q.ctrl[PCR_MON_EN_BIT];
	assign voltage_monitor_irq_o = s_q.irq;
	assign voltage_monitor_output_o = s_q.filt;
	assign wake_event_flag_o = s_q.wake_f;
	assign debug_powerdown_flag_o = s_q.dbg_f;

	// ------------------------------------------------
	// assertions
	// ------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i || core_por_i);

	property p_irq_gate;
		!s_q.ctrl[PCR_IRQ_EN_BIT] |=> !voltage_monitor_irq_o;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq raised while disabled");

	property p_filt_bypass;
		(s_q.ctrl[PCR_MON_EN_BIT] && !s_q.ctrl[PCR_FILT_EN_BIT]) |=> (s_q.filt == $past(s_q.cmp_s));
	endproperty
	a_filt_bypass: assert property (p_filt_bypass) else $error("bypass does not follow comparator");

	property p_filt_hold;
		(s_q.ctrl[PCR_MON_EN_BIT] && s_q.ctrl[PCR_FILT_EN_BIT] && fcnt != 8'h00 && !wr_ctrl
			&& !(lsi_rise && 8'(s_q.run + 8'h01) >= fcnt)) |=> $stable(s_q.filt);
	endproperty
	a_filt_hold: assert property (p_filt_hold) else $error("filter output changed early");

	sequence s_wake_clr;
		wr_ctrl && wval[PCR_WAKE_CLR_BIT];
	endsequence
	property p_wake_clr;
		s_wake_clr ##0 (!wake_pin_event_i)[*3] |=> !wake_event_flag_o;
	endproperty
	a_wake_clr: assert property (p_wake_clr) else $error("wake flag not cleared");

	property p_wake_early;
		s_wake_clr ##0 (!wake_pin_event_i) ##0 wake_event_flag_o |=> wake_event_flag_o;
	endproperty
	a_wake_early: assert property (p_wake_early) else $error("wake flag cleared too soon");

	property p_clr_read;
		(ack_o && !$past(we_i) && $past(adr_i) == PCR_CTRL_OFF) |-> (dat_o[PCR_WAKE_CLR_BIT] == 1'b0
			&& dat_o[PCR_DBG_CLR_BIT] == 1'b0);
	endproperty
	a_clr_read: assert property (p_clr_read) else $error("clear bit read nonzero");

	property p_mode;
		cpu_deep_sleep_signal_i |=> (stop_mode_o != power_down_mode_o)
			&& (power_down_mode_o == $past(s_q.ctrl[PCR_MODE_BIT]));
	endproperty
	a_mode: assert property (p_mode) else $error("wrong deep sleep mode");

	property p_wdg;
		watchdog_reset_req_i |=> (watchdog_sys_reset_o == $past(s_q.ctrl[PCR_WDG_BIT]));
	endproperty
	a_wdg: assert property (p_wdg) else $error("watchdog gate wrong");

	property p_dbg_clr;
		(wr_ctrl && wval[PCR_DBG_CLR_BIT] && !debug_pd_entry_i) |=> !debug_powerdown_flag_o;
	endproperty
	a_dbg_clr: assert property (p_dbg_clr) else $error("debug flag not cleared");

	property p_wake_set;
		wake_pin_event_i |=> wake_event_flag_o;
	endproperty
	a_wake_set: assert property (p_wake_set) else $error("wake flag not set");

	property p_mon_off;
		!s_q.ctrl[PCR_MON_EN_BIT] |=> !voltage_monitor_output_o ##1 !voltage_monitor_irq_o;
	endproperty
	a_mon_off: assert property (p_mon_off) else $error("monitor active while off");

	property p_irq_cause;
		voltage_monitor_irq_o |-> $past(s_q.filt) && $past(s_q.ctrl[PCR_MON_EN_BIT]);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");

	// ------------------------------------------------
	// filter and bus checks
	// ------------------------------------------------
	sequence s_filt_active;
		s_q.ctrl[PCR_MON_EN_BIT] && s_q.ctrl[PCR_FILT_EN_BIT] && fcnt != 8'h00;
	endsequence

	property p_filt_restart;
		s_filt_active ##0 (s_q.cmp_s == s_q.filt) |=> (s_q.run == 8'h00);
	endproperty
	a_filt_restart: assert property (p_filt_restart) else $error("filter count not restarted");

	property p_filt_pass;
		s_filt_active ##0 (s_q.cmp_s != s_q.filt && lsi_rise && 8'(s_q.run + 8'h01) >= fcnt)
			|=> (s_q.filt == $past(s_q.cmp_s));
	endproperty
	a_filt_pass: assert property (p_filt_pass) else $error("filter output did not follow");

	property p_ack_pulse;
		ack_o |=> !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");

	property p_reserved;
		(s_q.ctrl & ~PCR_CTRL_WMASK) == (PCR_CTRL_RESET & ~PCR_CTRL_WMASK);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits changed");
endmodule
`default_nettype wire

// File: verification/pcr_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module pcr_far_side (
	// clock
	input wire logic clk_i,
	// bench requests
	input wire logic cmp_req_i,
	input wire logic sleep_req_i,
	// far side pins
	output logic monitor_cmp_o,
	output logic cpu_deep_sleep_o,
	output logic lsi_o
);
	logic [2:0] div_q = 3'h0;
	// free running low-speed oscillator, eight system cycles a period
	always_ff @(posedge clk_i) begin
		div_q <= div_q + 3'h1;
	end
	assign lsi_o = div_q[2];
	assign monitor_cmp_o = cmp_req_i;
	assign cpu_deep_sleep_o = sleep_req_i;
endmodule
`default_nettype wire

// File: verification/pcr_power_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pcr_power_control_tb_top;
	import pcr_pkg::*;
	logic clk_i, rst_i, por, cyc, stb, we, cmp, slp, wk, dbg, wdg;
	logic mc, ds, low_speed_oscillator, stp, pd, wrst, edg, men, irq, mout, wf, df;
	logic [1:0] bor;
	logic [3:0] thr;
	logic [7:0] adr;
	logic [31:0] dat, rd, dat_o;
	logic ack_o;
	int fail_count = 0;
	int n_tests = 0;
	logic [31:0] wv [4] = '{32'h07fe_0fff, 32'h0000_0000, 32'h02aa_0540, 32'h0400_0202};
	logic [31:0] ev [4] = '{32'h07fe_0ff3, 32'h0000_0000, 32'h02aa_0540, 32'h0400_0202};
	pcr_far_side far (.clk_i(clk_i), .cmp_req_i(cmp), .sleep_req_i(slp), .monitor_cmp_o(mc),
		.cpu_deep_sleep_o(ds), .lsi_o(low_speed_oscillator));
	pcr_power_control uut (.clk_i(clk_i), .rst_i(rst_i), .core_por_i(por), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
		.monitor_cmp_i(mc), .low_speed_oscillator_i(low_speed_oscillator), .cpu_deep_sleep_signal_i(ds),
		.wake_pin_event_i(wk), .debug_pd_entry_i(dbg), .watchdog_reset_req_i(wdg),
		.stop_mode_o(stp), .power_down_mode_o(pd), .watchdog_sys_reset_o(wrst),
		.reset_pin_edge_select_o(edg), .stop_brownout_level_o(bor), .monitor_threshold_select_o(thr),
		.voltage_monitor_enable_o(men), .voltage_monitor_irq_o(irq), .voltage_monitor_output_o(mout),
		.wake_event_flag_o(wf), .debug_powerdown_flag_o(df));
	// ------------------------------------------------
	// tasks
	// ------------------------------------------------
	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int k;
		k = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'b1 && k < 50);
		if (k >= 50) begin
			fail_count++;
		end
		r = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic pulse(input int which);
		case (which)
			0: wk <= 1'b1;
			1: dbg <= 1'b1;
			default: rst_i <= 1'b1;
		endcase
		@(posedge clk_i);
		{wk, dbg, rst_i} <= 3'b000;
		repeat (2) @(posedge clk_i);
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// ------------------------------------------------
	// sequence
	// ------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		#200000;
		fail_count++;
		conclude();
	end
	initial begin
		{rst_i, por} = 2'b11;
		{cyc, stb, we, cmp, slp, wk, dbg, wdg} = 8'h00;
		adr = 8'h00;
		dat = 32'h0;
		repeat (8) @(posedge clk_i);
		{rst_i, por} <= 2'b00;
		@(posedge clk_i);
		wb(0, PCR_CTRL_OFF, 0, rd);
		chk("ctrl reset", 32'h0000_0601, rd);
		for (int i = 0; i < 4; i++) begin
			wb(1, PCR_CTRL_OFF, wv[i], rd);
			wb(0, PCR_CTRL_OFF, 0, rd);
			chk("ctrl", ev[i], rd);
			chk("fields", {24'h0, ev[i][11:4]}, {24'h0, edg, bor, thr, men});
		end
		$display("register table done");
		wdg <= 1'b1;
		slp <= 1'b1;
		wb(1, PCR_CTRL_OFF, 32'h0000_0002, rd);
		@(negedge clk_i);
		chk("pd sleep", 32'h2, {29'h0, stp, pd, wrst});
		wb(1, PCR_CTRL_OFF, 32'h0000_0001, rd);
		@(negedge clk_i);
		chk("stop sleep", 32'h5, {29'h0, stp, pd, wrst});
		{slp, wdg} <= 2'b00;
		pulse(0);
		pulse(1);
		wb(0, PCR_STAT_OFF, 0, rd);
		chk("flags set", 32'h3, rd);
		wb(1, PCR_CTRL_OFF, 32'h0000_0005, rd);
		@(negedge clk_i);
		chk("wake held", 32'h1, {31'h0, wf});
		@(negedge clk_i);
		chk("wake clear", 32'h0, {31'h0, wf});
		wb(1, PCR_CTRL_OFF, 32'h0000_0009, rd);
		wb(0, PCR_STAT_OFF, 0, rd);
		chk("debug clear", 32'h0, rd);
		$display("events done");
		wb(1, PCR_CTRL_OFF, 32'h0000_0401, rd);
		pulse(2);
		wb(0, PCR_CTRL_OFF, 0, rd);
		chk("warm reset", 32'h0000_0401, rd);
		wb(0, 8'h10, 0, rd);
		chk("unmapped", 32'h0, rd);
		cmp <= 1'b1;
		wb(1, PCR_CTRL_OFF, 32'h0400_0411, rd);
		repeat (6) @(negedge clk_i);
		chk("monitor irq", 32'h3, {30'h0, mout, irq});
		wb(1, PCR_CTRL_OFF, 32'h0606_0411, rd);
		cmp <= 1'b0;
		repeat (6) @(negedge clk_i);
		chk("filter holds", 32'h1, {31'h0, mout});
		repeat (60) @(negedge clk_i);
		chk("filter passes", 32'h0, {30'h0, mout, irq});
		$display("monitor done");
		conclude();
	end
endmodule
`default_nettype wire
